// >>> inc/lintrx_cfg.svh
// timing counts and encodings for the lin transceiver mode and wake block
// assumes a 200 MHz sys_clk
`ifndef LINTRX_CFG_SVH
`define LINTRX_CFG_SVH
`define LINTRX_CLK_MHZ 200
`define LINTRX_EN_TIME_US 10
`define LINTRX_EN_CYC (`LINTRX_EN_TIME_US * `LINTRX_CLK_MHZ)
`define LINTRX_WK_FILT_US 30
`define LINTRX_WK_FILT_CYC (`LINTRX_WK_FILT_US * `LINTRX_CLK_MHZ)
`define LINTRX_MODE_OFF 2'h0
`define LINTRX_MODE_WAKE 2'h1
`define LINTRX_MODE_RXONLY 2'h2
`define LINTRX_MODE_NORMAL 2'h3
`define LINTRX_MODE_RST 2'h0
`endif

// >>> inc/lintrx_pkg.sv
// types for the lin transceiver mode and wake block
// assumes lintrx_cfg.svh holds the numeric constants
package lintrx_pkg;
  typedef enum logic [2:0] {
    lintrx_sys_normal,
    lintrx_sys_stop,
    lintrx_sys_sleep,
    lintrx_sys_restart,
    lintrx_sys_failsafe,
    lintrx_sys_init
  } lintrx_sys_e;
  typedef enum logic [1:0] {
    lintrx_wk_idle,
    lintrx_wk_dom,
    lintrx_wk_long,
    lintrx_wk_woken
  } lintrx_wk_e;
endpackage : lintrx_pkg

// >>> tb/lintrx_host.sv
// host model: drives the transmit pins of both lanes
// assumes the bench tells it when to hold recessive
module lintrx_host (
  // clock
  input wire logic sys_clk,
  // bench control
  input wire logic [1:0] hold_rec,
  input wire logic [1:0] tx_bit,
  // pins
  output logic [1:0] bus_transmit_input
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_transmit_input = 2'h3;
  // clearing hold_rec lets the bench break the enable rule on purpose
  always @(posedge sys_clk)
    bus_transmit_input <= tx_bit | hold_rec;
endmodule : lintrx_host

// >>> tb/lintrx_monitor.sv
// concurrent checks on the lin mode and wake block
// bound into lintrx_top; sees only its ports
module lintrx_monitor #(
  parameter int EN_CYC = 8,
  parameter int WK_FILT_CYC = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // chip state and modes
  input wire lintrx_pkg::lintrx_sys_e sys_mode,
  input wire logic watchdog_on_bus_wake_enable,
  input wire logic watchdog_enabled,
  input wire logic [1:0] first_transceiver_mode_field,
  input wire logic [1:0] mode_effective_0,
  // results
  input wire logic [1:0] rx_out,
  input wire logic [1:0] bus_drive_dominant,
  input wire logic [1:0] wake_source_status_register,
  input wire logic wake_irq,
  input wire logic restart_request,
  input wire logic watchdog_force_enable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // driver and effective mode are registered at the same edge
  chk_drive_off_mode: assert property (
    mode_effective_0 != 2'h3 |-> !bus_drive_dominant[0])
    else $error("driver active outside normal mode");
  chk_enable_mask: assert property (
    mode_effective_0 == 2'h3 && $past(mode_effective_0) != 2'h3
    |-> (!bus_drive_dominant[0]) [*6])
    else $error("drive during enable time");
  chk_irq_sys_mode: assert property (
    wake_irq |-> $past(sys_mode) inside {lintrx_pkg::lintrx_sys_normal,
    lintrx_pkg::lintrx_sys_stop})
    else $error("interrupt outside stop or normal");
  chk_irq_sets_flag: assert property (
    wake_irq |-> wake_source_status_register != 2'h0)
    else $error("interrupt without wake flag");
  chk_restart_src: assert property (
    restart_request |-> !wake_irq && !($past(sys_mode) inside
    {lintrx_pkg::lintrx_sys_normal, lintrx_pkg::lintrx_sys_stop}))
    else $error("restart request in wrong mode");
  chk_wdog_cond: assert property (
    watchdog_force_enable |-> $past(watchdog_on_bus_wake_enable) &&
    !$past(watchdog_enabled) &&
    $past(sys_mode) == lintrx_pkg::lintrx_sys_stop)
    else $error("watchdog forced without cause");
  chk_rx_held: assert property (
    $rose(wake_source_status_register[0]) && mode_effective_0 == 2'h1
    |=> (!rx_out[0]) [*8])
    else $error("receive output not held low");
  chk_failsafe_wake: assert property (
    sys_mode == lintrx_pkg::lintrx_sys_failsafe
    |=> mode_effective_0 == 2'h1)
    else $error("fail-safe did not force wake mode");
  chk_sleep_off: assert property (
    sys_mode == lintrx_pkg::lintrx_sys_sleep &&
    first_transceiver_mode_field[1] |=> mode_effective_0 == 2'h0)
    else $error("active mode granted in sleep");
  chk_off_no_wake: assert property (
    (mode_effective_0 == 2'h0) [*8]
    |-> !$rose(wake_source_status_register[0]))
    else $error("wake reported in off mode");
endmodule : lintrx_monitor

bind lintrx_top lintrx_monitor #(
  .EN_CYC(EN_CYC),
  .WK_FILT_CYC(WK_FILT_CYC)
) i_mon (.sys_clk, .rst, .sys_mode, .watchdog_on_bus_wake_enable,
  .watchdog_enabled, .first_transceiver_mode_field, .mode_effective_0,
  .rx_out, .bus_drive_dominant, .wake_source_status_register,
  .wake_irq, .restart_request, .watchdog_force_enable);

// >>> tb/testbench.sv
// self-checking bench for the lin mode and wake block
// assumes design, host model and checker are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN = 8;
  localparam int WK = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  lintrx_pkg::lintrx_sys_e sys_mode = lintrx_pkg::lintrx_sys_normal;
  logic wd_cfg = 1'b0;
  logic wd_on = 1'b0;
  logic [1:0] fld0 = 2'h0;
  logic [1:0] fld1 = 2'h0;
  logic [1:0] hold_rec = 2'h3;
  logic [1:0] tx_bit = 2'h3;
  logic [1:0] ext_dom = 2'h0;
  logic [1:0] clr = 2'h0;
  logic [1:0] txd, rx, drv, flag, eff0, eff1;
  logic irq, rsq, wdf, b, e, d;
  logic [1:0] r;
  logic [7:0] hist;
  logic [1:0] md [3] = '{2'h3, 2'h2, 2'h0};
  int error_cnt = 0;
  int total_checks = 0;
  int n, m;
  // open lines are recessive unless someone pulls them
  wire logic [1:0] bus = ~(drv | ext_dom);
  lintrx_top #(.EN_CYC(EN), .WK_FILT_CYC(WK)) i_dut (.sys_clk, .rst,
    .sys_mode, .watchdog_on_bus_wake_enable(wd_cfg),
    .watchdog_enabled(wd_on), .first_transceiver_mode_field(fld0),
    .second_transceiver_mode_field(fld1), .bus_transmit_input(txd),
    .rx_out(rx), .bus_level(bus), .bus_drive_dominant(drv),
    .wake_source_status_register(flag), .wake_status_clear(clr),
    .wake_irq(irq), .restart_request(rsq),
    .watchdog_force_enable(wdf), .mode_effective_0(eff0),
    .mode_effective_1(eff1));
  lintrx_host i_host (.sys_clk, .hold_rec, .tx_bit,
    .bus_transmit_input(txd));
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  function automatic logic [1:0] exp_eff(int s, logic [1:0] f);
    if (s == 4)
      return 2'h1;
    if ((f[1] && s > 1) || (f == 2'h1 && s == 5))
      return 2'h0;
    return f;
  endfunction : exp_eff
  // ex holds rx low, interrupt, restart, watchdog pulse
  task automatic wake_step(int s, logic [1:0] f, logic c, int k,
    logic [3:0] ex);
    logic [2:0] seen;
    seen = 3'h0;
    @(posedge sys_clk);
    sys_mode <= lintrx_pkg::lintrx_sys_e'(s);
    fld0 <= f;
    wd_cfg <= c;
    cyc(4);
    @(posedge sys_clk) ext_dom[0] <= 1'b1;
    cyc(k);
    @(posedge sys_clk) ext_dom[0] <= 1'b0;
    repeat (30)
    begin
      cyc(1);
      seen = seen | {irq === 1'b1, rsq === 1'b1, wdf === 1'b1};
    end
    chk("wake pulses", 8'(seen), 8'(ex[2:0]));
    chk("wake flag", 8'(flag[0]), 8'(ex[2] | ex[1]));
    chk("mode kept", 8'(eff0), 8'(exp_eff(s, f)));
    if (ex[3])
      chk("rx low", 8'(rx[0]), 8'h0);
    @(posedge sys_clk) clr[0] <= 1'b1;
    @(posedge sys_clk) clr[0] <= 1'b0;
    cyc(1);
    chk("flag clear", 8'(flag[0]), 8'h0);
    $display("test wake step done");
  endtask : wake_step
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #50us;
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(98));
    cyc(2);
    chk("reset rx", 8'(rx), 8'h3);
    chk("reset mode", 8'({eff1, eff0}), 8'h0);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int s = 0; s < 6; s++)
      for (int f = 0; f < 4; f++)
      begin
        @(posedge sys_clk);
        sys_mode <= lintrx_pkg::lintrx_sys_e'(s);
        fld0 <= 2'(f);
        fld1 <= 2'(3 - f);
        cyc(2);
        chk("mode 0", 8'(eff0), 8'(exp_eff(s, 2'(f))));
        chk("mode 1", 8'(eff1), 8'(exp_eff(s, 2'(3 - f))));
      end
    $display("test mode table done");
    @(posedge sys_clk);
    sys_mode <= lintrx_pkg::lintrx_sys_normal;
    fld0 <= 2'h3;
    fld1 <= 2'h0;
    hold_rec <= 2'h0;
    tx_bit <= 2'h0;
    cyc(EN + 6);
    chk("early dominant", 8'(drv), 8'h0);
    @(posedge sys_clk) tx_bit[0] <= 1'b1;
    cyc(4);
    foreach (md[i])
    begin
      @(posedge sys_clk) fld0 <= md[i];
      repeat (12)
      begin
        b = 1'($urandom_range(1));
        e = 1'($urandom_range(1));
        @(posedge sys_clk);
        tx_bit[0] <= b;
        ext_dom[0] <= e;
        cyc(8);
        d = (md[i] == 2'h3) & !b;
        chk("drive", 8'(drv[0]), 8'(d));
        chk("rx", 8'(rx[0]), 8'((md[i] == 2'h0) | !(d | e)));
        chk("drive lane 1", 8'(drv[1]), 8'h0);
      end
    end
    $display("test transfer done");
    @(posedge sys_clk);
    tx_bit <= 2'h3;
    ext_dom <= 2'h0;
    wake_step(1, 2'h0, 1'b1, WK + 8, 4'h0);
    wake_step(1, 2'h1, 1'b1, WK - 6, 4'h0);
    wake_step(1, 2'h1, 1'b1, WK + 8, 4'hd);
    wake_step(1, 2'h1, 1'b1, WK + 8, 4'h8);
    wake_step(1, 2'h3, 1'b0, WK + 8, 4'h0);
    wake_step(0, 2'h1, 1'b0, WK + 8, 4'hc);
    wake_step(2, 2'h1, 1'b0, WK + 8, 4'ha);
    wake_step(4, 2'h0, 1'b0, WK + 8, 4'ha);
    // watchdog already running: no forced enable on wake
    @(posedge sys_clk) wd_on <= 1'b1;
    wake_step(1, 2'h1, 1'b1, WK + 8, 4'hc);
    // receive path: every level reaches rx four edges later, in order
    @(posedge sys_clk);
    sys_mode <= lintrx_pkg::lintrx_sys_normal;
    fld0 <= 2'h2;
    fld1 <= 2'h2;
    cyc(8);
    chk("rx idle", 8'(rx), 8'h3);
    n = 0;
    hist = 8'h0;
    repeat (40)
    begin
      @(posedge sys_clk);
      r = 2'($urandom_range(3));
      ext_dom <= r;
      #1;
      if (n >= 4)
      begin
        chk("rx lane 0", 8'(rx[0]), 8'(!hist[6]));
        chk("rx lane 1", 8'(rx[1]), 8'(!hist[7]));
      end
      hist = {hist[5:0], r};
      n++;
    end
    @(posedge sys_clk) ext_dom <= 2'h0;
    cyc(6);
    chk("rx settled", 8'(rx), 8'h3);
    $display("test receive path done");
    tally_and_finish();
  end
endmodule : testbench

// >>> verilog/lintrx_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
module lintrx_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;
  always_comb
  begin
    in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule : lintrx_fifo

// >>> verilog/lintrx_top.sv
// mode control and wake detection for two lin transceivers
// assumes system mode and mode fields come from the chip's own logic on
// sys_clk; transmit inputs and bus receiver levels are asynchronous pins
`include "lintrx_cfg.svh"
module lintrx_top #(
  parameter int EN_CYC = `LINTRX_EN_CYC,
  parameter int WK_FILT_CYC = `LINTRX_WK_FILT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // chip state
  input wire lintrx_pkg::lintrx_sys_e sys_mode,
  input wire logic watchdog_on_bus_wake_enable,
  input wire logic watchdog_enabled,
  // mode fields, one per transceiver
  input wire logic [1:0] first_transceiver_mode_field,
  input wire logic [1:0] second_transceiver_mode_field,
  // host pins
  input wire logic [1:0] bus_transmit_input,
  output logic [1:0] rx_out,
  // bus side: receiver level in, dominant drive out
  input wire logic [1:0] bus_level,
  output logic [1:0] bus_drive_dominant,
  // wake reporting
  output logic [1:0] wake_source_status_register,
  input wire logic [1:0] wake_status_clear,
  output logic wake_irq,
  output logic restart_request,
  output logic watchdog_force_enable,
  // effective mode, read back by the mode register logic
  output logic [1:0] mode_effective_0,
  output logic [1:0] mode_effective_1
);
  if (EN_CYC < 1 || WK_FILT_CYC < 1)
  begin : g_bad_timing
    $error("timing counts must be at least one cycle");
  end
  localparam int CW = $clog2(EN_CYC > WK_FILT_CYC ? EN_CYC + 2
                                                    : WK_FILT_CYC + 2);
  // two-flop synchronisers for pins
  logic [1:0] txd_s1, txd_s2, bus_s1, bus_s2;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      txd_s1 <= 2'h3;
      txd_s2 <= 2'h3;
      bus_s1 <= 2'h3;
      bus_s2 <= 2'h3;
    end
    else
    begin
      txd_s1 <= bus_transmit_input;
      txd_s2 <= txd_s1;
      bus_s1 <= bus_level;
      bus_s2 <= bus_s1;
    end
  end
  // bus levels pass a fifo so the receive path is buffered; it drains every
  // cycle, so it never fills and adds one fixed cycle of latency
  logic fifo_out_valid;
  logic [1:0] fifo_out_data;
  lintrx_fifo #(.WIDTH(2), .DEPTH(16)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(1'b1),
    .in_ready(),
    .in_data(bus_s2),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );
  logic [1:0] bus_now;
  assign bus_now = fifo_out_valid ? fifo_out_data : 2'h3;
  // last receive level; resets recessive so reset release is never an edge
  logic [1:0] bus_prev;
  lintrx_pkg::lintrx_sys_e sys_prev;
  logic rearm_sys;
  assign rearm_sys = (sys_mode != sys_prev) &&
    (sys_mode == lintrx_pkg::lintrx_sys_stop ||
     sys_mode == lintrx_pkg::lintrx_sys_sleep ||
     sys_mode == lintrx_pkg::lintrx_sys_failsafe);
  logic [1:0] mode_req [2];
  logic [1:0] mode_eff [2];
  logic [1:0] mode_prev [2];
  lintrx_pkg::lintrx_wk_e wk [2];
  lintrx_pkg::lintrx_wk_e next_wk [2];
  logic [CW-1:0] wcnt [2];
  logic [CW-1:0] next_wcnt [2];
  logic [CW-1:0] ecnt [2];
  logic [CW-1:0] next_ecnt [2];
  logic [1:0] tx_armed, next_tx_armed;
  logic [1:0] next_rx, next_drive, next_stat, wake_evt;
  logic next_irq, next_restart, next_wdog;
  assign mode_req[0] = first_transceiver_mode_field;
  assign mode_req[1] = second_transceiver_mode_field;
  always_comb
  begin
    next_irq = 1'b0;
    next_restart = 1'b0;
    next_wdog = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      mode_eff[i] = mode_req[i];
      if (sys_mode == lintrx_pkg::lintrx_sys_failsafe)
        mode_eff[i] = `LINTRX_MODE_WAKE;
      else if ((mode_req[i] == `LINTRX_MODE_NORMAL ||
                mode_req[i] == `LINTRX_MODE_RXONLY) &&
               sys_mode != lintrx_pkg::lintrx_sys_normal &&
               sys_mode != lintrx_pkg::lintrx_sys_stop)
        mode_eff[i] = `LINTRX_MODE_OFF;
      else if (mode_req[i] == `LINTRX_MODE_WAKE &&
               sys_mode == lintrx_pkg::lintrx_sys_init)
        mode_eff[i] = `LINTRX_MODE_OFF;
      // enabling time counter restarts on entry to normal mode
      next_ecnt[i] = ecnt[i];
      next_tx_armed[i] = tx_armed[i];
      if (mode_eff[i] != `LINTRX_MODE_NORMAL)
      begin
        next_ecnt[i] = '0;
        next_tx_armed[i] = 1'b0;
      end
      else if (ecnt[i] < CW'(EN_CYC))
        next_ecnt[i] = ecnt[i] + 1'b1;
      else if (txd_s2[i])
        next_tx_armed[i] = 1'b1;
      next_drive[i] = (mode_eff[i] == `LINTRX_MODE_NORMAL) &&
        tx_armed[i] && !txd_s2[i];
      // wake detector
      next_wk[i] = wk[i];
      next_wcnt[i] = wcnt[i];
      wake_evt[i] = 1'b0;
      if (mode_eff[i] != `LINTRX_MODE_WAKE)
      begin
        next_wk[i] = lintrx_pkg::lintrx_wk_idle;
        next_wcnt[i] = '0;
      end
      else if (rearm_sys)
      begin
        next_wk[i] = lintrx_pkg::lintrx_wk_idle;
        next_wcnt[i] = '0;
      end
      else
      begin
        case (wk[i])
          lintrx_pkg::lintrx_wk_idle:
          begin
            // only a fresh recessive-to-dominant edge starts a phase
            if (!bus_now[i] && bus_prev[i] &&
                mode_prev[i] == `LINTRX_MODE_WAKE)
              next_wk[i] = lintrx_pkg::lintrx_wk_dom;
            next_wcnt[i] = '0;
          end
          lintrx_pkg::lintrx_wk_dom:
          begin
            if (bus_now[i])
              next_wk[i] = lintrx_pkg::lintrx_wk_idle;
            else if (wcnt[i] >= CW'(WK_FILT_CYC))
              next_wk[i] = lintrx_pkg::lintrx_wk_long;
            else
              next_wcnt[i] = wcnt[i] + 1'b1;
          end
          lintrx_pkg::lintrx_wk_long:
          begin
            if (bus_now[i])
            begin
              next_wk[i] = lintrx_pkg::lintrx_wk_woken;
              wake_evt[i] = 1'b1;
            end
          end
          lintrx_pkg::lintrx_wk_woken:
            next_wk[i] = wk[i];
          default:
            next_wk[i] = lintrx_pkg::lintrx_wk_idle;
        endcase
      end
      if (mode_eff[i] == `LINTRX_MODE_OFF)
        next_rx[i] = 1'b1;
      else if (mode_eff[i] == `LINTRX_MODE_WAKE)
        next_rx[i] = !(wake_evt[i] ||
          wk[i] == lintrx_pkg::lintrx_wk_woken);
      else
        next_rx[i] = bus_now[i];
      // set wins over clear
      next_stat[i] = wake_evt[i] |
        (wake_source_status_register[i] & !wake_status_clear[i]);
      if (wake_evt[i])
      begin
        if (sys_mode == lintrx_pkg::lintrx_sys_stop ||
            sys_mode == lintrx_pkg::lintrx_sys_normal)
          next_irq = 1'b1;
        if (sys_mode == lintrx_pkg::lintrx_sys_sleep ||
            sys_mode == lintrx_pkg::lintrx_sys_failsafe)
          next_restart = 1'b1;
        if (sys_mode == lintrx_pkg::lintrx_sys_stop &&
            watchdog_on_bus_wake_enable && !watchdog_enabled)
          next_wdog = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_prev <= lintrx_pkg::lintrx_sys_init;
      bus_prev <= 2'h3;
      for (int i = 0; i < 2; i++)
      begin
        mode_prev[i] <= `LINTRX_MODE_RST;
        wk[i] <= lintrx_pkg::lintrx_wk_idle;
        wcnt[i] <= '0;
        ecnt[i] <= '0;
      end
      tx_armed <= 2'h0;
      rx_out <= 2'h3;
      bus_drive_dominant <= 2'h0;
      wake_source_status_register <= 2'h0;
      wake_irq <= 1'b0;
      restart_request <= 1'b0;
      watchdog_force_enable <= 1'b0;
      mode_effective_0 <= `LINTRX_MODE_RST;
      mode_effective_1 <= `LINTRX_MODE_RST;
    end
    else
    begin
      sys_prev <= sys_mode;
      bus_prev <= bus_now;
      for (int i = 0; i < 2; i++)
      begin
        mode_prev[i] <= mode_eff[i];
        wk[i] <= next_wk[i];
        wcnt[i] <= next_wcnt[i];
        ecnt[i] <= next_ecnt[i];
      end
      tx_armed <= next_tx_armed;
      rx_out <= next_rx;
      bus_drive_dominant <= next_drive;
      wake_source_status_register <= next_stat;
      wake_irq <= next_irq;
      restart_request <= next_restart;
      watchdog_force_enable <= next_wdog;
      mode_effective_0 <= mode_eff[0];
      mode_effective_1 <= mode_eff[1];
    end
  end
endmodule : lintrx_top
